/* File: inc/uwem_pkg.sv */
// upstream window / error mask package: offsets, field layout, reset values
// assumes a byte-addressed configuration port with 32-bit dwords
package uwem_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] UWEM_OFS_UPSTREAM_CTRL = 8'h48;
   localparam logic [7:0] UWEM_OFS_WINDOW_LOW    = 8'h50;
   localparam logic [7:0] UWEM_OFS_BASE_HIGH     = 8'h54;
   localparam logic [7:0] UWEM_OFS_LIMIT_HIGH    = 8'h58;
   localparam logic [7:0] UWEM_OFS_EVENT_MASK    = 8'h64;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int UWEM_WIN_EN_BIT    = 16;
   localparam int UWEM_BASE_TYPE_LSB = 0;
   localparam int UWEM_BASE_ADDR_LSB = 4;
   localparam int UWEM_LIM_TYPE_LSB  = 16;
   localparam int UWEM_LIM_ADDR_LSB  = 20;
   localparam int UWEM_GRAN_BITS     = 20;

   // mask bit positions
   localparam int UWEM_MSK_PW_PARITY  = 1;
   localparam int UWEM_MSK_PW_NODLV   = 2;
   localparam int UWEM_MSK_PW_TABORT  = 3;
   localparam int UWEM_MSK_PW_MABORT  = 4;
   localparam int UWEM_MSK_DW_NODLV   = 5;
   localparam int UWEM_MSK_DR_NODATA  = 6;
   localparam logic [7:0] UWEM_MSK_WRITABLE = 8'h7e;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [3:0]  UWEM_ADDR_TYPE_64 = 4'h1;
   localparam logic [11:0] UWEM_BASE_RST     = 12'h000;
   localparam logic [11:0] UWEM_LIMIT_RST    = 12'h000;
   localparam logic [31:0] UWEM_HIGH_RST     = 32'h0000_0000;
   localparam logic [7:0]  UWEM_MASK_RST     = 8'h00;

   // ------------------------------------------------------------
   // timing counts
   // ------------------------------------------------------------
   localparam int UWEM_RETRY_LIMIT = 1 << 24;

endpackage

/* File: rtl/uwem_retry_counter.sv */
// retry counter: declares non-delivery after a set number of retries
// assumes retry and done are single-cycle pulses from the forwarding engine
`timescale 1ns/1ps
module uwem_retry_counter #(
   parameter int LIMIT = 16777216
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic retry,
   input  wire logic done,
   output logic      fail_r
);
   localparam int W = $clog2(LIMIT + 1);
   localparam logic [W-1:0] LAST = W'(LIMIT - 1);

   if (LIMIT < 2) begin : g_bad_limit
      $error("uwem_retry_counter: LIMIT must be at least 2");
   end

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         fail_nxt;

   always_comb begin
      cnt_nxt  = cnt_r;
      fail_nxt = 1'b0;
      if (done) begin
         cnt_nxt = '0;
      end else if (retry) begin
         if (cnt_r == LAST) begin // RULE17
            fail_nxt = 1'b1;
            cnt_nxt  = '0;
         end else begin
            cnt_nxt = cnt_r + W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= '0;
         fail_r <= 1'b0;
      end else if (ce) begin
         cnt_r  <= cnt_nxt;
         fail_r <= fail_nxt;
      end
   end
endmodule // uwem_retry_counter

/* File: rtl/uwem_top.sv */
// upstream memory window and system-error event mask registers of a bridge
// assumes config accesses are single-cycle strobes synchronous to clk
`timescale 1ns/1ps

// Functional notes
// RULE1 - base register bits 15:4 hold writable upstream base, reset zero
// RULE2 - base bits 3:0 read-only, report 64-bit addressing, read 1
// RULE3 - limit register bits 31:20 hold writable upstream limit, reset zero
// RULE4 - limit bits 19:16 read-only, same encoding, read 1
// RULE5 - writable dword supplies base address bits 63:32, reset zero
// RULE6 - writable dword supplies limit address bits 63:32, reset zero
// RULE7 - event drives system error only if unmasked and error enable set
// RULE8 - mask bit 1 gates posted write parity event, reset 0
// RULE9 - mask bit 2 gates posted write non-delivery, reset 0
// RULE10 - mask bit 3 gates target abort on posted write, reset 0
// RULE11 - mask bit 4 gates master abort on posted write, reset 0
// RULE12 - mask bit 5 gates delayed write non-delivery, reset 0
// RULE13 - mask bit 6 gates delayed read no-data, reset 0
// RULE14 - mask bits 0 and 7 reserved, read zero
// RULE15 - window enable 0: all except downstream; 1: base to limit
// RULE16 - hit when base <= address <= limit, ignoring granularity bits
// RULE17 - non-delivery declared when retries of one transaction reach limit
module uwem_top
   import uwem_pkg::*;
#(
   parameter int RETRY_LIMIT = UWEM_RETRY_LIMIT
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata_r,
   output logic             cfg_rvalid_r,
   input  wire logic        system_error_enable_bit,
   input  wire logic        pw_parity_evt,
   input  wire logic        pw_retry,
   input  wire logic        pw_done,
   input  wire logic        pw_tabort_evt,
   input  wire logic        pw_mabort_evt,
   input  wire logic        dw_retry,
   input  wire logic        dw_done,
   input  wire logic        dr_retry,
   input  wire logic        dr_done,
   input  wire logic [63:0] sec_addr,
   input  wire logic        sec_addr_valid,
   input  wire logic        downstream_hit,
   output logic             upstream_hit_r,
   output logic             upstream_hit_valid_r,
   output logic             primary_system_error_out_r,
   output logic             primary_system_error_oe_r
);

   if (RETRY_LIMIT < 2) begin : g_bad_limit
      $error("uwem_top: RETRY_LIMIT must be at least 2");
   end

   // ------------------------------------------------------------
   // reset synchroniser
   // ------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic        win_en_r,  win_en_nxt;
   logic [11:0] base_r,    base_nxt;
   logic [11:0] limit_r,   limit_nxt;
   logic [31:0] base_hi_r, base_hi_nxt;
   logic [31:0] lim_hi_r,  lim_hi_nxt;
   logic [7:0]  mask_r,    mask_nxt;
   logic [31:0] rdata_nxt;

   // merge write data into a dword under byte enables
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
      end
      return r;
   endfunction

   logic [31:0] ctrl_word;
   logic [31:0] low_word;
   logic [31:0] low_merged;
   logic [31:0] ctrl_merged;
   logic [31:0] mask_merged;

   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[UWEM_WIN_EN_BIT] = win_en_r;
      low_word = {limit_r, UWEM_ADDR_TYPE_64, base_r, UWEM_ADDR_TYPE_64}; // RULE2 RULE4
      low_merged  = be_merge(low_word, cfg_wdata, cfg_be);
      ctrl_merged = be_merge(ctrl_word, cfg_wdata, cfg_be);
      mask_merged = be_merge({24'h000000, mask_r}, cfg_wdata, cfg_be);

      win_en_nxt  = win_en_r;
      base_nxt    = base_r;
      limit_nxt   = limit_r;
      base_hi_nxt = base_hi_r;
      lim_hi_nxt  = lim_hi_r;
      mask_nxt    = mask_r;
      if (cfg_wr) begin
         if (cfg_addr == UWEM_OFS_UPSTREAM_CTRL) begin
            win_en_nxt = ctrl_merged[UWEM_WIN_EN_BIT];
         end else if (cfg_addr == UWEM_OFS_WINDOW_LOW) begin
            base_nxt  = low_merged[UWEM_BASE_ADDR_LSB +: 12]; // RULE1
            limit_nxt = low_merged[UWEM_LIM_ADDR_LSB +: 12];  // RULE3
         end else if (cfg_addr == UWEM_OFS_BASE_HIGH) begin
            base_hi_nxt = be_merge(base_hi_r, cfg_wdata, cfg_be); // RULE5
         end else if (cfg_addr == UWEM_OFS_LIMIT_HIGH) begin
            lim_hi_nxt = be_merge(lim_hi_r, cfg_wdata, cfg_be); // RULE6
         end else if (cfg_addr == UWEM_OFS_EVENT_MASK) begin
            mask_nxt = mask_merged[7:0] & UWEM_MSK_WRITABLE; // RULE14
         end
      end

      // unmapped offsets read zero
      rdata_nxt = 32'h0000_0000;
      if (cfg_addr == UWEM_OFS_UPSTREAM_CTRL) begin
         rdata_nxt = ctrl_word;
      end else if (cfg_addr == UWEM_OFS_WINDOW_LOW) begin
         rdata_nxt = low_word;
      end else if (cfg_addr == UWEM_OFS_BASE_HIGH) begin
         rdata_nxt = base_hi_r;
      end else if (cfg_addr == UWEM_OFS_LIMIT_HIGH) begin
         rdata_nxt = lim_hi_r;
      end else if (cfg_addr == UWEM_OFS_EVENT_MASK) begin
         rdata_nxt = {24'h000000, mask_r & UWEM_MSK_WRITABLE}; // RULE14
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         win_en_r     <= 1'b0;
         base_r       <= UWEM_BASE_RST;
         limit_r      <= UWEM_LIMIT_RST;
         base_hi_r    <= UWEM_HIGH_RST;
         lim_hi_r     <= UWEM_HIGH_RST;
         mask_r       <= UWEM_MASK_RST;
         cfg_rdata_r  <= 32'h0000_0000;
         cfg_rvalid_r <= 1'b0;
      end else if (ce) begin
         win_en_r     <= win_en_nxt;
         base_r       <= base_nxt;
         limit_r      <= limit_nxt;
         base_hi_r    <= base_hi_nxt;
         lim_hi_r     <= lim_hi_nxt;
         mask_r       <= mask_nxt;
         cfg_rdata_r  <= cfg_rd ? rdata_nxt : cfg_rdata_r;
         cfg_rvalid_r <= cfg_rd;
      end
   end

   // ------------------------------------------------------------
   // upstream window decode
   // ------------------------------------------------------------
   // compare only above the 1 MB granularity; limit implies all-ones below
   logic [43:0] addr_top;
   logic [43:0] base_top;
   logic [43:0] lim_top;
   logic        hit_nxt;

   always_comb begin
      addr_top = sec_addr[63:UWEM_GRAN_BITS];
      base_top = {base_hi_r, base_r};
      lim_top  = {lim_hi_r, limit_r};
      if (win_en_r) begin
         hit_nxt = (addr_top >= base_top) && (addr_top <= lim_top); // RULE15 RULE16
      end else begin
         hit_nxt = !downstream_hit; // RULE15
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         upstream_hit_r       <= 1'b0;
         upstream_hit_valid_r <= 1'b0;
      end else if (ce) begin
         upstream_hit_r       <= sec_addr_valid & hit_nxt;
         upstream_hit_valid_r <= sec_addr_valid;
      end
   end

   // ------------------------------------------------------------
   // retry counters and system error
   // ------------------------------------------------------------
   logic [2:0] retry_v;
   logic [2:0] done_v;
   logic [2:0] fail_v;

   assign retry_v = {dr_retry, dw_retry, pw_retry};
   assign done_v  = {dr_done, dw_done, pw_done};

   for (genvar g = 0; g < 3; g++) begin : g_retry
      uwem_retry_counter #(
         .LIMIT (RETRY_LIMIT)
      ) u_cnt (
         .clk    (clk),
         .rst_n  (rst_n),
         .ce     (ce),
         .retry  (retry_v[g]),
         .done   (done_v[g]),
         .fail_r (fail_v[g])
      );
   end

   logic [7:0] evt_v;
   logic       serr_nxt;

   always_comb begin
      evt_v = 8'h00;
      evt_v[UWEM_MSK_PW_PARITY] = pw_parity_evt; // RULE8
      evt_v[UWEM_MSK_PW_NODLV]  = fail_v[0];     // RULE9
      evt_v[UWEM_MSK_PW_TABORT] = pw_tabort_evt; // RULE10
      evt_v[UWEM_MSK_PW_MABORT] = pw_mabort_evt; // RULE11
      evt_v[UWEM_MSK_DW_NODLV]  = fail_v[1];     // RULE12
      evt_v[UWEM_MSK_DR_NODATA] = fail_v[2];     // RULE13
      // open-drain: assert by enabling a low drive
      serr_nxt = system_error_enable_bit &&
                 |(evt_v & ~mask_r & UWEM_MSK_WRITABLE); // RULE7
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         primary_system_error_out_r <= 1'b0;
         primary_system_error_oe_r  <= 1'b0;
      end else if (ce) begin
         primary_system_error_out_r <= 1'b0;
         primary_system_error_oe_r  <= serr_nxt;
      end
   end

endmodule // uwem_top

/* File: test/uwem_host.sv */
// host model: issues single-cycle config strobes on the register port
// assumes one clock; requests change only at the falling edge
`timescale 1ns/1ps
module uwem_host (
   input  wire logic        clk,
   output logic             cfg_wr,
   output logic             cfg_rd,
   output logic [7:0]       cfg_addr,
   output logic [3:0]       cfg_be,
   output logic [31:0]      cfg_wdata
);
   initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;

   // released address and data lines show the inverse so stale values never look valid
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
      @(negedge clk);
      cfg_wr    = w;
      cfg_rd    = !w;
      cfg_addr  = a;
      cfg_be    = b;
      cfg_wdata = d;
      @(negedge clk);
      {cfg_wr, cfg_rd} = 2'b00;
      cfg_addr  = ~a;
      cfg_wdata = ~d;
   endtask
endmodule // uwem_host

/* File: test/uwem_top_sva.sv */
// port-level checker for uwem_top
// assumes rstn and ce straight from the bench; requests qualified by ce
`timescale 1ns/1ps
module uwem_chk (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        ce,
   input wire logic        cfg_rd,
   input wire logic [7:0]  cfg_addr,
   input wire logic [31:0] cfg_rdata_r,
   input wire logic        cfg_rvalid_r,
   input wire logic        system_error_enable_bit,
   input wire logic        pw_parity_evt,
   input wire logic        pw_retry,
   input wire logic        pw_tabort_evt,
   input wire logic        pw_mabort_evt,
   input wire logic        dw_retry,
   input wire logic        dr_retry,
   input wire logic        sec_addr_valid,
   input wire logic        upstream_hit_valid_r,
   input wire logic        primary_system_error_out_r,
   input wire logic        primary_system_error_oe_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_rv; ce && cfg_rd |=> cfg_rvalid_r; endproperty
   a_rv: assert property (p_rv) else $error("read not answered");
   property p_bt; cfg_rd && cfg_addr == 8'h50 |=> cfg_rdata_r[3:0] == 4'h1; endproperty
   a_bt: assert property (p_bt) else $error("base type wrong");
   property p_lt; cfg_rd && cfg_addr == 8'h50 |=> cfg_rdata_r[19:16] == 4'h1; endproperty
   a_lt: assert property (p_lt) else $error("limit type wrong");
   property p_rs; cfg_rd && cfg_addr == 8'h64 |=> !cfg_rdata_r[0] && cfg_rdata_r[31:7] == '0;
   endproperty
   a_rs: assert property (p_rs) else $error("reserved mask bits set");
   property p_so; primary_system_error_out_r == 1'b0; endproperty
   a_so: assert property (p_so) else $error("error line driven high");
   property p_en; !system_error_enable_bit [*3] |-> !primary_system_error_oe_r; endproperty
   a_en: assert property (p_en) else $error("error driven while disabled");
   // retry failures land two cycles late, pulse events one
   property p_qt; !$past(pw_retry || dw_retry || dr_retry, 2) &&
      !$past(pw_parity_evt || pw_tabort_evt || pw_mabort_evt) |-> !primary_system_error_oe_r;
   endproperty
   a_qt: assert property (p_qt) else $error("error driven without cause");
   property p_hv; ce && sec_addr_valid |=> upstream_hit_valid_r; endproperty
   a_hv: assert property (p_hv) else $error("query not answered");
endmodule // uwem_chk

bind uwem_top uwem_chk uwem_chk_i (.clk, .rstn, .ce, .cfg_rd, .cfg_addr, .cfg_rdata_r,
   .cfg_rvalid_r, .system_error_enable_bit, .pw_parity_evt, .pw_retry, .pw_tabort_evt,
   .pw_mabort_evt, .dw_retry, .dr_retry, .sec_addr_valid, .upstream_hit_valid_r,
   .primary_system_error_out_r, .primary_system_error_oe_r);

/* File: test/uwem_top_tb.sv */
// self-checking bench for uwem_top
// host model drives the config port; bench drives events and queries
`timescale 1ns/1ps
module uwem_top_tb;
   localparam int RL = 4;
   logic        clk = 0, rstn = 0, en = 0, dsh = 0, qv = 0, ce = 1;
   logic [6:0]  ev = '0;
   logic [2:0]  dn = '0;
   logic [63:0] qa = '0;
   wire         cfg_wr, cfg_rd, cfg_rvalid_r, hit, hitv, so, oe;
   wire [7:0]   cfg_addr;
   wire [3:0]   cfg_be;
   wire [31:0]  cfg_wdata, cfg_rdata_r;
   int          mismatches = 0, compares = 0, oec = 0, n;

   uwem_host uwem_host_i (.clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata);
   uwem_top #(.RETRY_LIMIT(RL)) uwem_top_i (.clk, .rstn, .ce(ce), .cfg_wr, .cfg_rd,
      .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata_r, .cfg_rvalid_r,
      .system_error_enable_bit(en), .pw_parity_evt(ev[1]), .pw_retry(ev[2]),
      .pw_done(dn[0]), .pw_tabort_evt(ev[3]), .pw_mabort_evt(ev[4]), .dw_retry(ev[5]),
      .dw_done(dn[1]), .dr_retry(ev[6]), .dr_done(dn[2]), .sec_addr(qa),
      .sec_addr_valid(qv), .downstream_hit(dsh), .upstream_hit_r(hit),
      .upstream_hit_valid_r(hitv), .primary_system_error_out_r(so),
      .primary_system_error_oe_r(oe));

   always #5 clk = ~clk;
   always @(posedge clk) if (oe === 1'b1) oec++;

   task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] s);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      uwem_host_i.xfer(1'b0, a, 4'h0, '0);
      cmp("rvalid", 1, cfg_rvalid_r);
      cmp("rdata", e, cfg_rdata_r);
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      uwem_host_i.xfer(1'b1, a, b, d);
   endtask
   task automatic q(input logic [63:0] a, input logic d, input logic e);
      @(negedge clk);
      qa  = a;
      qv  = 1;
      dsh = d;
      @(negedge clk);
      qv  = 0;
      qa  = ~a;
      dsh = !d;
      cmp("hit_valid", 1, hitv);
      cmp("hit", e, hit);
   endtask
   // k pulses on event b, then a done pulse, then count error drives
   task automatic fire(input int b, input int k, input int e);
      oec = 0;
      repeat (k) begin
         @(negedge clk);
         ev[b] = 1'b1;
      end
      @(negedge clk);
      ev = '0;
      dn = 3'b111;
      @(negedge clk);
      dn = '0;
      repeat (4) @(negedge clk);
      cmp("oe_count", e, oec);
      cmp("serr_level", 0, so);
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #100us;
      mismatches++;
      summarize();
   end

   initial begin
      repeat (10) @(negedge clk);
      rstn = 1;
      repeat (3) @(negedge clk);
      rd(8'h50, 32'h0001_0001);
      rd(8'h54, 0);
      rd(8'h58, 0);
      rd(8'h64, 0);
      rd(8'h48, 0);
      wr(8'h48, 4'hf, '1);
      wr(8'h50, 4'hf, '1);
      wr(8'h54, 4'hf, '1);
      wr(8'h58, 4'hf, '1);
      wr(8'h64, 4'hf, '1);
      wr(8'h60, 4'hf, '1);
      rd(8'h50, 32'hfff1_fff1);
      rd(8'h54, '1);
      rd(8'h58, '1);
      rd(8'h64, 32'h7e);
      rd(8'h48, 32'h0001_0000);
      rd(8'h60, 0);
      // let the last rvalid pulse fall before freezing
      @(negedge clk);
      ce = 0;
      wr(8'h54, 4'hf, 32'h1234_5678);
      uwem_host_i.xfer(1'b0, 8'h54, 4'h0, '0);
      cmp("rvalid_frozen", 0, cfg_rvalid_r);
      ce = 1;
      rd(8'h54, '1);
      wr(8'h50, 4'h5, 0);
      rd(8'h50, 32'hff01_ff01);
      $display("test registers done");
      wr(8'h50, 4'hf, 32'h0020_0010);
      wr(8'h54, 4'hf, 1);
      wr(8'h58, 4'hf, 1);
      q(64'h1_0010_0000, 0, 1);
      q(64'h1_002f_ffff, 1, 1);
      q(64'h1_0030_0000, 0, 0);
      q(64'h1_000f_ffff, 0, 0);
      q(64'h2_0010_0000, 0, 0);
      wr(8'h48, 4'hf, 0);
      q(64'h1_0010_0000, 1, 0);
      q(64'h0, 0, 1);
      $display("test window done");
      wr(8'h64, 4'h1, 0);
      en = 1;
      for (int b = 1; b < 7; b++) begin
         n = (b == 2 || b == 5 || b == 6) ? RL : 1;
         fire(b, n, 1);
         wr(8'h64, 4'h1, 32'h1 << b);
         fire(b, n, 0);
         wr(8'h64, 4'h1, 32'h7e ^ (32'h1 << b));
         fire(b, n, 1);
         wr(8'h64, 4'h1, 0);
      end
      fire(2, RL - 1, 0);
      fire(2, RL - 1, 0);
      en = 0;
      fire(3, 1, 0);
      $display("test error events done");
      summarize();
   end
endmodule // uwem_top_tb
